// >>> otfh_defines.svh
`ifndef OTFH_DEFINES_SVH
`define OTFH_DEFINES_SVH

// ****************************************
// command codes
// ****************************************
`define OTFH_CODE_FAULT_LIM 8'h4F
`define OTFH_CODE_ACTION    8'h50
`define OTFH_CODE_WARN_LIM  8'h51

// ****************************************
// reset values, as restored from nvm
// ****************************************
`define OTFH_FAULT_LIM_RST  16'h007D
`define OTFH_WARN_LIM_RST   16'h0069
`define OTFH_ACTION_RST     8'h80

// ****************************************
// action byte fields
// ****************************************
`define OTFH_MODE_HI        7
`define OTFH_MODE_LO        6
`define OTFH_RETRY_HI       5
`define OTFH_RETRY_LO       3
`define OTFH_DELAY_HI       2
`define OTFH_DELAY_LO       0
`define OTFH_MODE_IGNORE    2'h0
`define OTFH_MODE_DELAYED   2'h1
`define OTFH_MODE_IMMED     2'h2
`define OTFH_MODE_COOL      2'h3
`define OTFH_RETRY_LATCH    3'h0
`define OTFH_RETRY_FOREVER  3'h7

// ****************************************
// linear format and temperatures
// ****************************************
`define OTFH_FRAC_BITS      16
`define OTFH_NVM_MIN_DEG    0
`define OTFH_NVM_MAX_DEG    160
`define OTFH_DISABLE_DEG    255
`define OTFH_HYST_DEG       20

// ****************************************
// timing
// ****************************************
`define OTFH_CLK_MHZ        100
`define OTFH_DELAY_STEP_MS  10
`define OTFH_DELAY_STEP_CYC (`OTFH_DELAY_STEP_MS * `OTFH_CLK_MHZ * 1000)

`endif

// >>> otfh_overtemp_fault_handler.sv
`timescale 1ns/1ps
`include "otfh_defines.svh"

// Behaviour
// - restore rounds fault limit to whole 0..160 degrees, except 255
// - limit 255 disables programmable fault check
// - compare limits at full linear resolution
// - fault sets temp, otf flags, alerts host
// - release fault below warning limit
// - warning above fault: release 20 below fault
// - ignore mode keeps running
// - delayed mode shuts after 10ms times delay
// - immediate mode shuts down, then retries
// - cool mode holds off until below warning
// - retry zero latches off
// - retries one to six, then latch off
// - retry seven retries forever
// - hot attempts are hidden but counted
// - delay zero: no delay, hiccup one rise
// - delay n: n steps, hiccup n rises
// - invalid action write flags data, alerts host
// - clear in cool band may hold fault
// - never start while fault is present
module otfh_overtemp_fault_handler #(
   parameter int unsigned DELAY_STEP_CYCLES = `OTFH_DELAY_STEP_CYC
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        enable_pin_in,
   input  wire logic [15:0] temp_in,
   input  wire logic [31:0] ton_rise_cycles_in,
   input  wire logic        startup_done_in,
   input  wire logic        clear_faults_in,
   input  wire logic        nvm_restore_in,
   input  wire logic        wr_en_in,
   input  wire logic [7:0]  wr_code_in,
   input  wire logic [15:0] wr_data_in,
   input  wire logic [7:0]  rd_code_in,
   output logic             power_enable_out,
   output logic             overheat_condition_out,
   output logic             status_temp_out,
   output logic             status_otf_out,
   output logic             cml_data_out,
   output logic             host_alert_out,
   output logic             latched_off_out,
   output logic [15:0]      rd_data_out
);

   localparam logic signed [47:0] ONE_DEG = 48'sh1_0000;

   otfh_pkg::otfh_state_t st;
   otfh_pkg::otfh_state_t next_st;

   logic signed [47:0] fault_fix;
   logic signed [47:0] warn_fix;
   logic signed [47:0] temp_fix;
   logic signed [47:0] release_fix;
   logic               fault_off;
   logic               above;
   logic               below;
   logic               shut;
   logic               act_invalid;
   logic [1:0]         fault_action_select;
   logic [2:0]         restart_attempt_policy;
   logic [2:0]         shutdown_delay_select;
   logic [31:0]        delay_cyc;
   logic [31:0]        hiccup_cyc;

   // ****************************************
   // linear format helpers
   // ****************************************
   function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
      logic signed [4:0]  e;
      logic signed [47:0] m;
      e = v[15:11];
      m = 48'(signed'(v[10:0]));
      lin_fix = m <<< 6'(int'(e) + `OTFH_FRAC_BITS);
   endfunction

   // nearest whole degree, clamped to the stored range; 255 survives as disable
   function automatic logic [15:0] round_nvm(input logic [15:0] v);
      logic signed [47:0] f;
      logic signed [47:0] r;
      f = lin_fix(v);
      r = (f + (ONE_DEG >>> 1)) >>> `OTFH_FRAC_BITS;
      if (f == 48'(`OTFH_DISABLE_DEG) * ONE_DEG) begin
         round_nvm = 16'(`OTFH_DISABLE_DEG);
      end else if (r < 48'(`OTFH_NVM_MIN_DEG)) begin
         round_nvm = 16'(`OTFH_NVM_MIN_DEG);
      end else if (r > 48'(`OTFH_NVM_MAX_DEG)) begin
         round_nvm = 16'(`OTFH_NVM_MAX_DEG);
      end else begin
         round_nvm = {5'h00, r[10:0]};
      end
   endfunction

   // ****************************************
   // thresholds and timing
   // ****************************************
   always_comb begin
      fault_action_select    = st.action[`OTFH_MODE_HI:`OTFH_MODE_LO];
      restart_attempt_policy = st.action[`OTFH_RETRY_HI:`OTFH_RETRY_LO];
      shutdown_delay_select  = st.action[`OTFH_DELAY_HI:`OTFH_DELAY_LO];
      fault_fix = lin_fix(st.fault_lim);
      warn_fix  = lin_fix(st.warn_lim);
      temp_fix  = lin_fix(temp_in);
      fault_off = fault_fix == 48'(`OTFH_DISABLE_DEG) * ONE_DEG;
      release_fix = (warn_fix > fault_fix) ? fault_fix - 48'(`OTFH_HYST_DEG) * ONE_DEG
                                           : warn_fix;
      above = !fault_off && (temp_fix > fault_fix);
      below = temp_fix < release_fix;
      delay_cyc  = 32'(shutdown_delay_select) * 32'(DELAY_STEP_CYCLES);
      hiccup_cyc = ((shutdown_delay_select == 3'h0) ? 32'h1 : 32'(shutdown_delay_select))
                   * ton_rise_cycles_in;
      // a delayed shutdown with no delay is refused as contradictory
      act_invalid = (wr_data_in[`OTFH_MODE_HI:`OTFH_MODE_LO] == `OTFH_MODE_DELAYED)
                    && (wr_data_in[`OTFH_DELAY_HI:`OTFH_DELAY_LO] == 3'h0);
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_st     = st;
      shut        = 1'b0;
      next_st.en1 = enable_pin_in;
      next_st.en2 = st.en1;

      if (above) begin
         next_st.overheat = 1'b1;
      end else if (below) begin
         next_st.overheat = 1'b0;
      end

      if (clear_faults_in) begin
         next_st.st_temp = 1'b0;
         next_st.st_otf  = 1'b0;
         next_st.cml     = 1'b0;
      end
      // flags set on a new fault, set wins over clear
      if (next_st.overheat && !st.overheat) begin
         next_st.st_temp = 1'b1;
         next_st.st_otf  = 1'b1;
      end

      if (wr_en_in) begin
         unique case (wr_code_in)
            `OTFH_CODE_FAULT_LIM: next_st.fault_lim = wr_data_in;
            `OTFH_CODE_WARN_LIM:  next_st.warn_lim  = wr_data_in;
            `OTFH_CODE_ACTION: begin
               if (act_invalid) begin
                  next_st.cml = 1'b1;
               end else begin
                  next_st.action = wr_data_in[7:0];
               end
            end
            default: next_st.cml = 1'b1;
         endcase
      end

      if (nvm_restore_in) begin
         next_st.fault_lim = round_nvm(next_st.fault_lim);
         next_st.warn_lim  = round_nvm(next_st.warn_lim);
      end

      unique case (rd_code_in)
         `OTFH_CODE_FAULT_LIM: next_st.rd_data = st.fault_lim;
         `OTFH_CODE_WARN_LIM:  next_st.rd_data = st.warn_lim;
         `OTFH_CODE_ACTION:    next_st.rd_data = {8'h00, st.action};
         default:              next_st.rd_data = 16'h0000;
      endcase

      unique case (st.fsm)
         otfh_pkg::OTFH_OFF: begin
            if (st.en2 && !st.overheat) begin
               next_st.fsm      = otfh_pkg::OTFH_START;
               next_st.attempts = 3'h0;
            end
         end
         otfh_pkg::OTFH_START, otfh_pkg::OTFH_RUN: begin
            if (st.fsm == otfh_pkg::OTFH_START && startup_done_in) begin
               next_st.fsm      = otfh_pkg::OTFH_RUN;
               next_st.attempts = 3'h0;
            end
            if (st.overheat) begin
               unique case (fault_action_select)
                  `OTFH_MODE_IGNORE: ;
                  `OTFH_MODE_DELAYED: begin
                     next_st.fsm = otfh_pkg::OTFH_DELAY;
                     next_st.cnt = delay_cyc;
                  end
                  `OTFH_MODE_IMMED: shut = 1'b1;
                  `OTFH_MODE_COOL: next_st.fsm = otfh_pkg::OTFH_COOL;
               endcase
            end
         end
         otfh_pkg::OTFH_DELAY: begin
            if (!st.overheat) begin
               next_st.fsm = otfh_pkg::OTFH_RUN;
            end else if (st.cnt == 32'h0) begin
               shut = 1'b1;
            end else begin
               next_st.cnt = st.cnt - 32'h1;
            end
         end
         otfh_pkg::OTFH_HICCUP: begin
            if (st.cnt != 32'h0) begin
               next_st.cnt = st.cnt - 32'h1;
            end else if (restart_attempt_policy != `OTFH_RETRY_FOREVER
                         && st.attempts >= restart_attempt_policy) begin
               next_st.fsm = otfh_pkg::OTFH_LATCHED;
            end else begin
               next_st.attempts = st.attempts + 3'h1;
               if (st.overheat) begin
                  next_st.cnt = hiccup_cyc;
               end else begin
                  next_st.fsm = otfh_pkg::OTFH_START;
               end
            end
         end
         otfh_pkg::OTFH_COOL: begin
            // clear inside the band holds the fault
            if (clear_faults_in && !below) begin
               next_st.fsm = otfh_pkg::OTFH_STUCK;
            end else if (!st.overheat) begin
               shut = 1'b1;
            end
         end
         otfh_pkg::OTFH_STUCK: begin
            if (above) begin
               next_st.fsm = otfh_pkg::OTFH_COOL;
            end
         end
         otfh_pkg::OTFH_LATCHED: ;
      endcase

      // latch off, else wait one hiccup
      if (shut) begin
         if (restart_attempt_policy == `OTFH_RETRY_LATCH) begin
            next_st.fsm = otfh_pkg::OTFH_LATCHED;
         end else begin
            next_st.fsm = otfh_pkg::OTFH_HICCUP;
            next_st.cnt = hiccup_cyc;
         end
      end

      // disabling the output ends any fault sequence, including a latch
      if (!st.en2) begin
         next_st.fsm = otfh_pkg::OTFH_OFF;
         next_st.cnt = 32'h0;
      end

      next_st.power = next_st.fsm == otfh_pkg::OTFH_START
                      || next_st.fsm == otfh_pkg::OTFH_RUN
                      || next_st.fsm == otfh_pkg::OTFH_DELAY;
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st           <= '0;
         st.fault_lim <= `OTFH_FAULT_LIM_RST;
         st.warn_lim  <= `OTFH_WARN_LIM_RST;
         st.action    <= `OTFH_ACTION_RST;
         st.fsm       <= otfh_pkg::OTFH_OFF;
      end else begin
         st <= next_st;
      end
   end

   assign power_enable_out       = st.power;
   assign overheat_condition_out = st.overheat;
   assign status_temp_out        = st.st_temp;
   assign status_otf_out         = st.st_otf;
   assign cml_data_out           = st.cml;
   assign host_alert_out         = st.st_otf | st.cml;
   assign latched_off_out        = st.fsm == otfh_pkg::OTFH_LATCHED;
   assign rd_data_out            = st.rd_data;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   chk_disabled_no_fault: assert property (
      (fault_off && !st.overheat) |=> !st.overheat)
      else $error("fault raised while check disabled");
   chk_fault_flags_alert: assert property (
      $rose(st.overheat) |-> (st.st_temp && st.st_otf && host_alert_out))
      else $error("fault without status flags or alert");
   chk_release_below: assert property (
      (st.overheat && below) |=> !st.overheat)
      else $error("fault not released below release level");
   chk_ignore_runs: assert property (
      (st.fsm == otfh_pkg::OTFH_RUN && st.en2 && fault_action_select == `OTFH_MODE_IGNORE)
      |=> power_enable_out)
      else $error("ignore mode stopped the output");
   chk_immediate_shut: assert property (
      (st.fsm == otfh_pkg::OTFH_RUN && st.en2 && st.overheat
       && fault_action_select == `OTFH_MODE_IMMED) |=> !power_enable_out)
      else $error("immediate mode kept running");
   chk_retry_zero_latch: assert property (
      (shut && st.en2 && restart_attempt_policy == `OTFH_RETRY_LATCH)
      |=> latched_off_out[*2])
      else $error("retry zero did not latch off");
   chk_action_refused: assert property (
      (wr_en_in && wr_code_in == `OTFH_CODE_ACTION && act_invalid)
      |=> (cml_data_out && host_alert_out && $stable(st.action)))
      else $error("invalid action write not refused");
   chk_no_start_hot: assert property (
      (st.fsm == otfh_pkg::OTFH_OFF && st.overheat) |=> !power_enable_out)
      else $error("started while fault present");
   chk_attempts_cleared: assert property (
      (st.fsm == otfh_pkg::OTFH_START && startup_done_in && st.en2 && !st.overheat)
      |=> (st.attempts == 3'h0))
      else $error("attempt count kept after startup");

endmodule

// >>> otfh_pkg.sv
`include "otfh_defines.svh"

package otfh_pkg;

   typedef enum logic [2:0] {
      OTFH_OFF,
      OTFH_START,
      OTFH_RUN,
      OTFH_DELAY,
      OTFH_HICCUP,
      OTFH_COOL,
      OTFH_STUCK,
      OTFH_LATCHED
   } otfh_fsm_t;

   typedef struct packed {
      logic        en1;
      logic        en2;
      logic [15:0] fault_lim;
      logic [15:0] warn_lim;
      logic [7:0]  action;
      otfh_fsm_t   fsm;
      logic [31:0] cnt;
      logic [2:0]  attempts;
      logic        overheat;
      logic        st_temp;
      logic        st_otf;
      logic        cml;
      logic        power;
      logic [15:0] rd_data;
   } otfh_state_t;

endpackage

// >>> otfh_power_stage_model.sv
`timescale 1ns/1ps

// ****************************************
// soft-start model of the power stage
// ****************************************
module otfh_power_stage_model (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        power_enable_in,
   input  wire logic [31:0] rise_in,
   input  wire logic        slow_in,
   output logic             startup_done_out
);
   logic [31:0] ramp;

   always @(posedge clk_in) begin
      if (rst_in || !power_enable_in) begin
         ramp <= 32'h0000_0000;
      end else if (ramp != 32'hFFFF_FFFF) begin
         ramp <= ramp + 32'h0000_0001;
      end
   end

   // start-up success
   // a slow stage needs twice the rise time; done drops with power
   assign startup_done_out = power_enable_in && (ramp >= (slow_in ? rise_in * 2 : rise_in));
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps

module tb_top;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        en = 1'b0;
   logic [15:0] temp = 16'h0064;
   logic        done;
   logic        clr = 1'b0;
   logic        rest = 1'b0;
   logic        wr_en = 1'b0;
   logic [7:0]  wr_code = 8'h00;
   logic [15:0] wr_data = 16'h0000;
   logic [7:0]  rd_code = 8'h00;
   logic        slow = 1'b1;
   logic        pwr, hot, st_t, st_o, cml, alert, latch;
   logic [15:0] rd_data;
   int          n_fail = 0;
   int          n_tests = 0;
   int          cyc = 0;

   always #5 clk_in = ~clk_in;

   otfh_overtemp_fault_handler #(.DELAY_STEP_CYCLES(20)) dut (
      .clk_in(clk_in), .rst_in(rst_in), .enable_pin_in(en), .temp_in(temp),
      .ton_rise_cycles_in(32'h0000_0008), .startup_done_in(done),
      .clear_faults_in(clr), .nvm_restore_in(rest), .wr_en_in(wr_en),
      .wr_code_in(wr_code), .wr_data_in(wr_data), .rd_code_in(rd_code),
      .power_enable_out(pwr), .overheat_condition_out(hot), .status_temp_out(st_t),
      .status_otf_out(st_o), .cml_data_out(cml), .host_alert_out(alert),
      .latched_off_out(latch), .rd_data_out(rd_data));

   otfh_power_stage_model stage (
      .clk_in(clk_in), .rst_in(rst_in), .power_enable_in(pwr),
      .rise_in(32'h0000_0008), .slow_in(slow), .startup_done_out(done));

   task automatic test_done();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // the whole run needs well under a thousand cycles
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end

   task automatic bad(input string m);
      n_fail++;
      $display("BAD %0t %s", $time, m);
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      n_tests++;
      if (g !== e) begin
         bad($sformatf("%s got %h want %h", m, g, e));
      end
   endtask

   function automatic logic o(input int s);
      case (s)
         0: return pwr;
         1: return hot;
         default: return latch;
      endcase
   endfunction

   // output s must keep level v for n cycles
   task automatic hold(input int s, input logic v, input int n);
      n_tests++;
      for (int k = 0; k < n; k++) begin
         @(posedge clk_in);
         #1;
         if (o(s) !== v) begin
            bad($sformatf("out %0d left %b", s, v));
            break;
         end
      end
   endtask

   // output s must reach level v within n cycles
   task automatic wait_for(input int s, input logic v, input int n);
      int k;
      n_tests++;
      for (k = 0; k < n && o(s) !== v; k++) begin
         @(posedge clk_in);
         #1;
      end
      if (o(s) !== v) begin
         bad($sformatf("out %0d never %b", s, v));
      end
   endtask

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk_in);
      wr_en <= 1'b1;
      wr_code <= c;
      wr_data <= d;
      @(posedge clk_in);
      wr_en <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      @(posedge clk_in);
      rd_code <= c;
      @(posedge clk_in);
      @(posedge clk_in);
      #1;
      chk(rd_data, e, "read");
   endtask

   task automatic pulse(input bit restore);
      @(posedge clk_in);
      if (restore) rest <= 1'b1;
      else clr <= 1'b1;
      @(posedge clk_in);
      rest <= 1'b0;
      clr <= 1'b0;
      #1;
   endtask

   task automatic heat(input logic [15:0] t);
      @(posedge clk_in);
      temp <= t;
   endtask

   task automatic power(input logic v);
      @(posedge clk_in);
      en <= v;
      wait_for(0, v, 12);
   endtask

   initial begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(8'h4F, 16'h007D);
      rd(8'h50, 16'h0080);
      rd(8'h51, 16'h0069);
      rd(8'h52, 16'h0000);
      wr(8'h52, 16'h0001);
      chk(16'({cml, alert}), 16'h0003, "unmapped write");
      pulse(0);
      wr(8'h50, 16'h0048);
      chk(16'({cml, alert}), 16'h0003, "invalid action");
      rd(8'h50, 16'h0080);
      pulse(0);
      // restore rounds 124.75 up and clamps 170 down
      wr(8'h4F, 16'hF1F3);
      wr(8'h51, 16'h00AA);
      pulse(1);
      rd(8'h4F, 16'h007D);
      rd(8'h51, 16'h00A0);
      wr(8'h51, 16'h0069);
      wr(8'h4F, 16'h00FF);
      pulse(1);
      rd(8'h4F, 16'h00FF);
      heat(16'h012C);
      hold(1, 1'b0, 10);
      heat(16'h007D);
      wr(8'h4F, 16'h007D);
      hold(1, 1'b0, 5);
      wr(8'h4F, 16'hF8F9);
      wait_for(1, 1'b1, 4);
      wr(8'h4F, 16'h007D);
      wr(8'h50, 16'h0000);
      heat(16'h0082);
      @(posedge clk_in);
      en <= 1'b1;
      hold(0, 1'b0, 20);
      heat(16'h0064);
      wait_for(0, 1'b1, 12);
      hold(0, 1'b1, 20);
      pulse(0);
      heat(16'h0082);
      wait_for(1, 1'b1, 4);
      chk(16'({st_t, st_o, alert}), 16'h0007, "flags");
      hold(0, 1'b1, 20);
      heat(16'h006A);
      hold(1, 1'b1, 5);
      heat(16'h0068);
      wait_for(1, 1'b0, 4);
      wr(8'h51, 16'h0082);
      heat(16'h0082);
      wait_for(1, 1'b1, 4);
      heat(16'h006A);
      hold(1, 1'b1, 5);
      heat(16'h0068);
      wait_for(1, 1'b0, 4);
      wr(8'h51, 16'h0069);
      power(0);
      slow <= 1'b0;
      wr(8'h50, 16'h0080);
      power(1);
      heat(16'h0082);
      wait_for(0, 1'b0, 4);
      wait_for(2, 1'b1, 4);
      heat(16'h0064);
      power(0);
      wait_for(2, 1'b0, 4);
      wr(8'h50, 16'h0091);
      power(1);
      hold(0, 1'b1, 12);
      heat(16'h0082);
      wait_for(0, 1'b0, 4);
      hold(0, 1'b0, 12);
      heat(16'h0064);
      wait_for(0, 1'b1, 20);
      hold(0, 1'b1, 12);
      heat(16'h0082);
      wait_for(0, 1'b0, 4);
      hold(2, 1'b0, 20);
      wait_for(2, 1'b1, 20);
      heat(16'h0064);
      power(0);
      wr(8'h50, 16'h007A);
      power(1);
      hold(0, 1'b1, 12);
      heat(16'h0082);
      hold(0, 1'b1, 30);
      wait_for(0, 1'b0, 20);
      hold(2, 1'b0, 100);
      heat(16'h0064);
      wait_for(0, 1'b1, 40);
      power(0);
      wr(8'h50, 16'h00C8);
      power(1);
      hold(0, 1'b1, 12);
      heat(16'h0082);
      wait_for(0, 1'b0, 4);
      heat(16'h006E);
      hold(0, 1'b0, 30);
      pulse(0);
      heat(16'h0064);
      hold(0, 1'b0, 30);
      heat(16'h0082);
      wait_for(1, 1'b1, 4);
      heat(16'h0064);
      wait_for(0, 1'b1, 30);
      test_done();
   end
endmodule
